// [hw/dmsp_top.sv]
// Purpose: Dual-mode serial port: asynchronous and clock-synchronous links.
// Assumes: Bus strobes and pins are synchronous to core_clk.
// Notes: Registers sit at their I/O addresses; reads answer one cycle later.
`include "dmsp_params.svh"
`timescale 1ns/1ns
`default_nettype none
module dmsp_top import dmsp_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // CPU I/O memory access.
  input wire dmsp_bus_s bus,
  output logic [7:0] rdata,
  // Serial pins.
  input wire logic rxd_pin,
  input wire logic sclk_pin,
  output dmsp_pad_s pad,
  // Port drive used while the pins are general-purpose.
  input wire logic gpio_txd,
  input wire logic gpio_txd_oe,
  input wire logic gpio_sclk,
  input wire logic gpio_sclk_oe,
  // Programmable timer underflow pulse.
  input wire logic timer_tick
);

  dmsp_mode_s mode_ff;
  dmsp_tx_e tx_state_ff, nxt_tx_state;
  dmsp_rx_e rx_state_ff, nxt_rx_state;
  logic [10:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_os_ff, nxt_tx_os, tx_left_ff, nxt_tx_left;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic [3:0] rx_os_ff, nxt_rx_os, rx_idx_ff, nxt_rx_idx;
  logic rx_acc_ff, nxt_rx_acc;
  logic [7:0] data_ff, rdata_ff;
  logic fer_ff, per_ff, oer_ff, rx_full_ff;
  logic tx_allow_ff, rx_allow_ff;
  logic sclk_ff, sclk_q_ff;
  logic [3:0] sync_cnt_ff;

  // ==========================================================
  // Decode
  logic wr_mode, wr_stat, wr_data, rd_data;
  logic is_async, is8, master, slave, takeover, tick;
  assign wr_mode = bus.wr && (bus.addr == `DMSP_ADDR_MODE);
  assign wr_stat = bus.wr && (bus.addr == `DMSP_ADDR_STAT);
  assign wr_data = bus.wr && (bus.addr == `DMSP_ADDR_DATA);
  assign rd_data = bus.rd && (bus.addr == `DMSP_ADDR_DATA);
  assign is_async = mode_ff.format_sel[1];
  assign is8 = (mode_ff.format_sel == FMT_ASYNC8);
  assign master = (mode_ff.format_sel == FMT_SYNC_MASTER);
  assign slave = (mode_ff.format_sel == FMT_SYNC_SLAVE);
  assign takeover = mode_ff.port_takeover;

  dmsp_shift_clock u_shift_clock (
    .core_clk(core_clk),
    .reset(reset),
    .run(takeover),
    .sel(mode_ff.shift_clock_sel),
    .timer_tick(timer_tick),
    .tick(tick)
  );

  // ==========================================================
  // Synchronous-mode clock
  logic sync_act, s_rise, s_fall, sync_last;
  assign sync_act = !is_async && (tx_state_ff == TX_SHIFT || rx_state_ff == RX_SHIFT);
  assign s_rise = sync_act && (master ? (tick && !sclk_ff) : (sclk_pin && !sclk_q_ff));
  assign s_fall = sync_act && (master ? (tick && sclk_ff) : (!sclk_pin && sclk_q_ff));
  assign sync_last = s_rise && (sync_cnt_ff == `DMSP_SYNC_LAST);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclk_ff <= 1'b1;
      sclk_q_ff <= 1'b1;
      sync_cnt_ff <= 4'h0;
    end else begin
      sclk_ff <= (!sync_act) ? 1'b1 : ((master && tick) ? !sclk_ff : sclk_ff);
      sclk_q_ff <= sclk_pin;
      sync_cnt_ff <= (!sync_act) ? 4'h0 : (s_rise ? sync_cnt_ff + 4'h1 : sync_cnt_ff);
    end
  end

  // ==========================================================
  // Transmitter
  logic tx_start, tx_par, tx_busy, tx_bit_end;
  logic [3:0] tx_len;
  logic [10:0] tx_frame;
  assign tx_busy = (tx_state_ff == TX_SHIFT);
  assign tx_start = wr_stat && bus.wdata[`DMSP_B_TX_GO] && bus.wdata[`DMSP_B_TX_ALLOW]
                    && takeover && !tx_busy;
  assign tx_par = (is8 ? ^data_ff : ^data_ff[6:0]) ^ mode_ff.parity_odd_select;
  assign tx_len = `DMSP_ASYNC_BASE + {3'h0, is8} + {3'h0, mode_ff.parity_on};
  assign tx_frame = is8 ? (mode_ff.parity_on ? {1'b1, tx_par, data_ff, 1'b0}
                                             : {2'h3, data_ff, 1'b0})
                        : (mode_ff.parity_on ? {2'h3, tx_par, data_ff[6:0], 1'b0}
                                             : {3'h7, data_ff[6:0], 1'b0});
  assign tx_bit_end = tick && (tx_os_ff == `DMSP_OS_LAST);

  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_os = tx_os_ff;
    nxt_tx_left = tx_left_ff;
    case (tx_state_ff)
      TX_IDLE: begin
        if (tx_start) begin
          nxt_tx_state = TX_SHIFT;
          nxt_tx_sh = is_async ? tx_frame : {3'h7, data_ff};
          nxt_tx_os = 4'h0;
          nxt_tx_left = tx_len;
        end
      end
      TX_SHIFT: begin
        if (!tx_allow_ff || !takeover) begin
          nxt_tx_state = TX_IDLE;
        end else if (is_async) begin
          if (tick) begin
            nxt_tx_os = tx_os_ff + 4'h1;
          end
          if (tx_bit_end) begin
            nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
            nxt_tx_left = tx_left_ff - 4'h1;
            if (tx_left_ff == 4'h1) begin
              nxt_tx_state = TX_IDLE;
            end
          end
        end else begin
          if (s_fall && sync_cnt_ff != 4'h0) begin
            nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
          end
          if (sync_last) begin
            nxt_tx_state = TX_IDLE;
          end
        end
      end
      default: nxt_tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_state_ff <= TX_IDLE;
      tx_sh_ff <= 11'h7FF;
      tx_os_ff <= 4'h0;
      tx_left_ff <= 4'h0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_sh_ff <= nxt_tx_sh;
      tx_os_ff <= nxt_tx_os;
      tx_left_ff <= nxt_tx_left;
    end
  end

  // ==========================================================
  // Receiver
  logic rx_start, rx_busy, rx_abort, rx_sample, rx_done, rx_fer_ev, rx_per_ev;
  logic [3:0] rx_n, rx_last;
  logic [7:0] rx_word;
  assign rx_busy = (rx_state_ff != RX_IDLE);
  assign rx_start = wr_stat && bus.wdata[`DMSP_B_RX_GO] && bus.wdata[`DMSP_B_RX_ALLOW]
                    && takeover && !rx_busy;
  assign rx_abort = !rx_allow_ff || !takeover;
  assign rx_n = is8 ? `DMSP_DATA_BITS8 : `DMSP_DATA_BITS7;
  assign rx_last = rx_n + 4'h1 + {3'h0, mode_ff.parity_on};
  assign rx_sample = is_async && tick && (rx_os_ff == `DMSP_OS_MID);
  assign rx_done = (rx_state_ff == RX_SHIFT) && !rx_abort
                   && (is_async ? (rx_sample && rx_idx_ff == rx_last) : sync_last);
  assign rx_word = !is_async ? {rxd_pin, rx_sh_ff[7:1]}
                             : (is8 ? rx_sh_ff : {1'b0, rx_sh_ff[7:1]});
  assign rx_fer_ev = rx_done && is_async && !rxd_pin;
  assign rx_per_ev = rx_done && is_async && mode_ff.parity_on
                     && (rx_acc_ff != mode_ff.parity_odd_select);

  always_comb begin
    nxt_rx_state = rx_state_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_os = rx_os_ff;
    nxt_rx_idx = rx_idx_ff;
    nxt_rx_acc = rx_acc_ff;
    case (rx_state_ff)
      RX_IDLE: begin
        if (rx_start) begin
          nxt_rx_state = is_async ? RX_HUNT : RX_SHIFT;
        end
      end
      RX_HUNT: begin
        if (rx_abort) begin
          nxt_rx_state = RX_IDLE;
        end else if (!rxd_pin) begin
          nxt_rx_state = RX_SHIFT;
          nxt_rx_os = 4'h0;
          nxt_rx_idx = 4'h0;
          nxt_rx_acc = 1'b0;
        end
      end
      RX_SHIFT: begin
        if (rx_abort || rx_done) begin
          nxt_rx_state = RX_IDLE;
        end else if (is_async) begin
          if (tick) begin
            nxt_rx_os = rx_os_ff + 4'h1;
          end
          if (rx_sample) begin
            nxt_rx_idx = rx_idx_ff + 4'h1;
            if (rx_idx_ff == 4'h0 && rxd_pin) begin
              nxt_rx_state = RX_HUNT;
            end else if (rx_idx_ff != 4'h0 && rx_idx_ff <= rx_n) begin
              nxt_rx_sh = {rxd_pin, rx_sh_ff[7:1]};
              nxt_rx_acc = rx_acc_ff ^ rxd_pin;
            end else if (rx_idx_ff != 4'h0) begin
              nxt_rx_acc = rx_acc_ff ^ rxd_pin;
            end
          end
        end else if (s_rise) begin
          nxt_rx_sh = {rxd_pin, rx_sh_ff[7:1]};
        end
      end
      default: nxt_rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_state_ff <= RX_IDLE;
      rx_sh_ff <= 8'h00;
      rx_os_ff <= 4'h0;
      rx_idx_ff <= 4'h0;
      rx_acc_ff <= 1'b0;
    end else begin
      rx_state_ff <= nxt_rx_state;
      rx_sh_ff <= nxt_rx_sh;
      rx_os_ff <= nxt_rx_os;
      rx_idx_ff <= nxt_rx_idx;
      rx_acc_ff <= nxt_rx_acc;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_ff <= `DMSP_MODE_RESET;
      tx_allow_ff <= `DMSP_FLAG_RESET;
      rx_allow_ff <= `DMSP_FLAG_RESET;
    end else if (wr_mode) begin
      mode_ff <= dmsp_mode_s'(bus.wdata[`DMSP_MODE_MSB:0]);
    end else if (wr_stat) begin
      tx_allow_ff <= bus.wdata[`DMSP_B_TX_ALLOW];
      rx_allow_ff <= bus.wdata[`DMSP_B_RX_ALLOW];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fer_ff <= `DMSP_FLAG_RESET;
      per_ff <= `DMSP_FLAG_RESET;
      oer_ff <= `DMSP_FLAG_RESET;
      rx_full_ff <= `DMSP_FLAG_RESET;
    end else begin
      fer_ff <= rx_fer_ev || (fer_ff && !(wr_stat && bus.wdata[`DMSP_B_FRAME]));
      per_ff <= rx_per_ev || (per_ff && !(wr_stat && bus.wdata[`DMSP_B_PARITY]));
      oer_ff <= (rx_done && rx_full_ff)
                || (oer_ff && !(wr_stat && bus.wdata[`DMSP_B_OVER]));
      rx_full_ff <= rx_done || (rx_full_ff && !rd_data);
    end
  end

  // Holds no reset: its content is undefined until written or received.
  always_ff @(posedge core_clk) begin
    if (wr_data) begin
      data_ff <= bus.wdata;
    end else if (rx_done) begin
      data_ff <= rx_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        `DMSP_ADDR_MODE: rdata_ff <= {1'b0, mode_ff};
        `DMSP_ADDR_STAT: rdata_ff <= {1'b0, fer_ff, per_ff, oer_ff, rx_busy, rx_allow_ff,
                                      tx_busy, tx_allow_ff};
        `DMSP_ADDR_DATA: rdata_ff <= data_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end
  assign rdata = rdata_ff;

  // ==========================================================
  // Pins
  assign pad.txd = takeover ? (!tx_busy || tx_sh_ff[0]) : gpio_txd;
  assign pad.txd_oe = takeover ? 1'b1 : gpio_txd_oe;
  assign pad.sclk = takeover ? sclk_ff : gpio_sclk;
  assign pad.sclk_oe = takeover ? master : gpio_sclk_oe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_mode_after_reset: assert property ($past(reset) |-> mode_ff == 7'h00)
    else $error("Mode register not cleared by reset.");
  a_tx_go_busy: assert property (tx_start |=> tx_busy && tx_left_ff == tx_len)
    else $error("Transmit trigger did not start a frame.");
  a_start_bit_low: assert property ($rose(tx_busy) && is_async |-> !pad.txd)
    else $error("Frame did not open with a low start bit.");
  a_idle_line_high: assert property (takeover && !tx_busy |-> pad.txd)
    else $error("Idle line not high.");
  a_slave_no_drive: assert property (slave && takeover |-> !pad.sclk_oe)
    else $error("Slave drove the shift clock.");
  a_port_release: assert property (!takeover |-> pad.txd == gpio_txd
                                   && pad.txd_oe == gpio_txd_oe)
    else $error("Pins not returned to the port.");
  a_fault_clear: assert property (wr_stat && bus.wdata[`DMSP_B_FRAME] && !rx_fer_ev
                                  |=> !fer_ff)
    else $error("Frame fault flag not cleared.");
  a_overrun_set: assert property (rx_done && rx_full_ff |=> oer_ff && rdata_ff == $past(rdata_ff)
                                  || oer_ff)
    else $error("Overrun not flagged.");
  a_allow_stops: assert property (!tx_allow_ff && tx_busy |=> !tx_busy)
    else $error("Transmit continued while disabled.");
  a_rx_store: assert property (rx_done && !wr_data |=> data_ff == $past(rx_word))
    else $error("Received word not stored.");

  c_async_frame: cover property (is_async && rx_done);
  c_sync_master: cover property (master && sync_last);
  c_parity_fault: cover property (rx_per_ev);
  c_overrun: cover property (rx_done && rx_full_ff);

endmodule // dmsp_top
`default_nettype wire

// [hw/dmsp_params.svh]
// Purpose: Constants of the dual-mode serial port: addresses, bit fields, counts.
// Assumes: Included by the top and shift-clock modules and by the bench; the package file does not include it.
// Notes: Definitions only.
`ifndef DMSP_PARAMS_SVH
`define DMSP_PARAMS_SVH

// ==========================================================
// Register addresses
`define DMSP_ADDR_MODE 16'hFF48
`define DMSP_ADDR_STAT 16'hFF49
`define DMSP_ADDR_DATA 16'hFF4A

// ==========================================================
// Reset values
`define DMSP_MODE_RESET 7'h00
`define DMSP_FLAG_RESET 1'h0

// ==========================================================
// Status register bit positions and mode register top bit
`define DMSP_B_FRAME 6
`define DMSP_B_PARITY 5
`define DMSP_B_OVER 4
`define DMSP_B_RX_GO 3
`define DMSP_B_RX_ALLOW 2
`define DMSP_B_TX_GO 1
`define DMSP_B_TX_ALLOW 0
`define DMSP_MODE_MSB 6

// ==========================================================
// Timing counts in shift-clock ticks and core clocks, and frame lengths in bits
`define DMSP_DIV4_LAST 4'h3
`define DMSP_DIV8_LAST 4'h7
`define DMSP_DIV16_LAST 4'hF
`define DMSP_OS_LAST 4'hF
`define DMSP_OS_MID 4'h7
`define DMSP_SYNC_LAST 4'h7
`define DMSP_ASYNC_BASE 4'h9
`define DMSP_DATA_BITS8 4'h8
`define DMSP_DATA_BITS7 4'h7

`endif

// [hw/dmsp_pkg.sv]
// Purpose: Types shared by the dual-mode serial port modules.
// Assumes: Nothing beyond a SystemVerilog compiler.
// Notes: Field order of the mode struct matches the mode register bits 6..0.
package dmsp_pkg;

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    FMT_SYNC_MASTER = 2'h0,
    FMT_SYNC_SLAVE = 2'h1,
    FMT_ASYNC7 = 2'h2,
    FMT_ASYNC8 = 2'h3
  } dmsp_fmt_e;

  typedef enum logic [1:0] {
    CLK_DIV16 = 2'h0,
    CLK_DIV8 = 2'h1,
    CLK_DIV4 = 2'h2,
    CLK_TIMER = 2'h3
  } dmsp_clk_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_SHIFT = 2'h2
  } dmsp_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_HUNT = 3'h2,
    RX_SHIFT = 3'h4
  } dmsp_rx_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic parity_on;
    logic parity_odd_select;
    logic [1:0] shift_clock_sel;
    logic [1:0] format_sel;
    logic port_takeover;
  } dmsp_mode_s;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dmsp_bus_s;

  typedef struct packed {
    logic txd;
    logic txd_oe;
    logic sclk;
    logic sclk_oe;
  } dmsp_pad_s;

endpackage

// [hw/dmsp_shift_clock.sv]
// Purpose: Shift-clock tick source of the serial port.
// Assumes: timer_tick is a one-cycle pulse from the programmable timer.
// Notes: tick is a one-cycle pulse; the divider restarts while run is low.
`include "dmsp_params.svh"
`timescale 1ns/1ns
`default_nettype none
module dmsp_shift_clock import dmsp_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Control.
  input wire logic run,
  input wire logic [1:0] sel,
  input wire logic timer_tick,
  // Tick out.
  output logic tick
);

  logic [3:0] div_ff;
  logic [3:0] nxt_div;
  logic [3:0] div_last;
  logic div_hit;

  // ==========================================================
  // Divider
  assign div_last = (sel == CLK_DIV4) ? `DMSP_DIV4_LAST :
                    (sel == CLK_DIV8) ? `DMSP_DIV8_LAST : `DMSP_DIV16_LAST;
  assign div_hit = (div_ff >= div_last);
  assign nxt_div = (!run || div_hit) ? 4'h0 : div_ff + 4'h1;
  assign tick = run && ((sel == CLK_TIMER) ? timer_tick : div_hit);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  a_div_four_gap: assert property (@(posedge core_clk) disable iff (reset)
    (tick && sel == CLK_DIV4) |=> !tick [*3])
    else $error("Divide-by-4 tick came early.");

endmodule // dmsp_shift_clock
`default_nettype wire

// [verif/dmsp_peer.sv]
// Purpose: Far-side serial peer: async line partner and sync clock partner.
// Assumes: Lines are sampled on core_clk; the bench sets rate and length.
// Notes: Async frames are captured raw, start bit in bit 0.
`timescale 1ns/1ns
`default_nettype none
module dmsp_peer (
  // Clock.
  input wire logic core_clk,
  // Serial lines.
  input wire logic txd,
  input wire logic sclk,
  output logic rxd
);
  int bit_cyc = 64;
  int cap_len = 10;
  bit mon_on = 0;
  bit sync_on = 0;
  int sync_n = 0;
  logic sclk_d = 1'b1;
  // The master's last rise ends the frame in the same cycle, so the bit is taken one cycle late.
  logic txd_d = 1'b1;
  logic [7:0] sync_out;
  logic [7:0] sync_in;
  logic [10:0] cap;
  logic [10:0] cap_q[$];
  initial rxd = 1'b1;
  // ==========================================================
  // Async capture, sampled at mid-bit.
  initial forever begin
    wait (mon_on);
    @(negedge txd);
    cap = '1;
    repeat (bit_cyc / 2) @(posedge core_clk);
    for (int i = 0; i < cap_len; i++) begin
      cap[i] = txd;
      if (i < cap_len - 1) repeat (bit_cyc) @(posedge core_clk);
    end
    cap_q.push_back(cap);
  end
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      rxd = bits[i];
      repeat (bit_cyc - 1) @(negedge core_clk);
    end
    rxd = 1'b1;
  endtask
  // ==========================================================
  // Sync partner: data changes on falls, sampled on rises.
  task automatic sync_start(input logic [7:0] v);
    sync_out = v;
    sync_n = 0;
    rxd = v[0];
    sync_on = 1;
  endtask
  always @(posedge core_clk) begin
    sclk_d <= sclk;
    txd_d <= txd;
    if (sync_on && sclk_d && !sclk && sync_n < 8) rxd <= sync_out[sync_n];
    if (sync_on && !sclk_d && sclk && sync_n < 8) begin
      sync_in[sync_n] <= txd_d;
      sync_n <= sync_n + 1;
    end
  end
endmodule // dmsp_peer
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: Self-checking bench of the dual-mode serial port.
// Assumes: Bus strobes and pins are driven on the falling edge, except the peer's sync-mode rxd data, which changes on the rising edge.
// Notes: Frames are predicted by a small integer model.
`include "dmsp_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top import dmsp_pkg::*;;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  dmsp_bus_s bus = '0;
  logic [7:0] rdata;
  logic rxd_pin;
  logic sclk_pin = 1'b1;
  dmsp_pad_s pad;
  logic gpio_txd = 1'b1;
  logic gpio_txd_oe = 1'b0;
  logic gpio_sclk = 1'b1;
  logic gpio_sclk_oe = 1'b0;
  logic timer_tick = 1'b0;
  bit tick_on = 0;
  int tick_cnt = 0;
  int num_errors = 0;
  int check_count = 0;
  bit unread = 0;
  logic [7:0] rv;
  int sel_t[9] = '{2, 2, 2, 2, 2, 2, 1, 0, 3};
  int cyc_t[4] = '{256, 128, 64, 80};
  dmsp_top dmsp_top_i (.core_clk(core_clk), .reset(reset), .bus(bus), .rdata(rdata),
    .rxd_pin(rxd_pin), .sclk_pin(sclk_pin), .pad(pad), .gpio_txd(gpio_txd),
    .gpio_txd_oe(gpio_txd_oe), .gpio_sclk(gpio_sclk), .gpio_sclk_oe(gpio_sclk_oe),
    .timer_tick(timer_tick));
  dmsp_peer dmsp_peer_i (.core_clk(core_clk), .txd(pad.txd),
    .sclk(pad.sclk_oe ? pad.sclk : sclk_pin), .rxd(rxd_pin));
  initial forever #5 core_clk = ~core_clk;
  // The timer pulses once every five cycles while enabled.
  always @(negedge core_clk) begin
    tick_cnt = (tick_cnt + 1) % 5;
    timer_tick = tick_on && tick_cnt == 0;
  end
  // ==========================================================
  // Helpers.
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge core_clk);
    bus = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(negedge core_clk);
    bus.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge core_clk);
    bus = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge core_clk);
    bus.rd = 1'b0;
    @(negedge core_clk);
    v = rdata;
  endtask
  task automatic wait_idle(input logic [7:0] m);
    int n;
    n = 0;
    rd(`DMSP_ADDR_STAT, rv);
    while ((rv & m) !== 8'h00 && n < 4000) begin
      rd(`DMSP_ADDR_STAT, rv);
      n++;
    end
    check(rv & m, 0);
  endtask
  function automatic logic [10:0] frame(input logic [7:0] v, input int nb, input int po,
    input int odd);
    int ones;
    frame = '1;
    frame[0] = 1'b0;
    ones = odd;
    for (int i = 0; i < nb; i++) begin
      frame[i + 1] = v[i];
      ones += v[i];
    end
    if (po != 0) frame[nb + 1] = 1'(ones % 2);
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Scenarios.
  task automatic async_tx(input int k);
    int nb, po, odd, sel;
    logic [7:0] d;
    sel = sel_t[k];
    nb = (k < 3 || k > 5) ? 8 : 7;
    po = (k < 6 && k % 3 != 0);
    odd = (k % 3 == 2);
    d = 8'($urandom);
    tick_on = (sel == 3);
    dmsp_peer_i.bit_cyc = cyc_t[sel];
    dmsp_peer_i.cap_len = nb + 2 + po;
    wr(`DMSP_ADDR_MODE, {1'b0, 1'(po), 1'(odd), 2'(sel), nb == 8 ? FMT_ASYNC8 : FMT_ASYNC7,
      1'b1});
    check({pad.txd, pad.txd_oe}, 3);
    dmsp_peer_i.mon_on = 1;
    wr(`DMSP_ADDR_DATA, d);
    wr(`DMSP_ADDR_STAT, 8'h03);
    rd(`DMSP_ADDR_STAT, rv);
    check(rv[1], 1);
    wait_idle(8'h02);
    dmsp_peer_i.mon_on = 0;
    check(11'(dmsp_peer_i.cap_q.size()), 1);
    if (dmsp_peer_i.cap_q.size() > 0)
      check(dmsp_peer_i.cap_q.pop_front(), frame(d, nb, po, odd));
  endtask
  task automatic async_rx(input int bad_par, input int bad_stop, input int read_it);
    logic [7:0] v;
    logic [10:0] ef;
    v = 8'($urandom);
    ef = frame(v, 8, 1, 0);
    ef[9] ^= 1'(bad_par);
    ef[10] = 1'(!bad_stop);
    dmsp_peer_i.bit_cyc = 64;
    wr(`DMSP_ADDR_MODE, 8'h57);
    wr(`DMSP_ADDR_STAT, 8'h0C);
    rd(`DMSP_ADDR_STAT, rv);
    check(rv[3], 1);
    dmsp_peer_i.send(ef, 11);
    wait_idle(8'h08);
    check(rv[6:4], {1'(bad_stop), 1'(bad_par), unread});
    if (read_it) begin
      rd(`DMSP_ADDR_DATA, rv);
      check(rv, v);
    end
    unread = !read_it;
    wr(`DMSP_ADDR_STAT, 8'h70);
    rd(`DMSP_ADDR_STAT, rv);
    check(rv, 0);
  endtask
  task automatic sync_xfer(input int slave);
    logic [7:0] d, e;
    d = 8'($urandom);
    e = 8'($urandom);
    wr(`DMSP_ADDR_MODE, slave ? 8'h1B : 8'h11);
    check(pad.sclk_oe, 1'(!slave));
    wr(`DMSP_ADDR_DATA, d);
    dmsp_peer_i.sync_start(e);
    wr(`DMSP_ADDR_STAT, 8'h0F);
    if (slave) repeat (16) begin
      repeat (8) @(negedge core_clk);
      sclk_pin = ~sclk_pin;
    end
    wait_idle(8'h0A);
    dmsp_peer_i.sync_on = 0;
    rd(`DMSP_ADDR_DATA, rv);
    check(rv, e);
    check(dmsp_peer_i.sync_in, d);
  endtask
  // ==========================================================
  // Main sequence and watchdog.
  initial begin
    logic [7:0] m;
    void'($urandom(83651));
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    rd(`DMSP_ADDR_MODE, rv);
    check(rv, 0);
    rd(`DMSP_ADDR_STAT, rv);
    check(rv, 0);
    rd(16'hFF4B, rv);
    check(rv, 0);
    m = 8'($urandom);
    wr(`DMSP_ADDR_MODE, m);
    rd(`DMSP_ADDR_MODE, rv);
    check(rv, m & 8'h7F);
    wr(`DMSP_ADDR_MODE, 8'h00);
    repeat (4) begin
      {gpio_txd, gpio_txd_oe, gpio_sclk, gpio_sclk_oe} = 4'($urandom);
      @(negedge core_clk);
      check(pad, {gpio_txd, gpio_txd_oe, gpio_sclk, gpio_sclk_oe});
    end
    $display("test registers and pins done");
    for (int k = 0; k < 9; k++) async_tx(k);
    tick_on = 0;
    $display("test async transmit done");
    rd(`DMSP_ADDR_DATA, rv);
    async_rx(0, 0, 1);
    async_rx(1, 0, 1);
    async_rx(0, 1, 1);
    async_rx(0, 0, 0);
    async_rx(0, 0, 1);
    $display("test async receive done");
    sync_xfer(0);
    sync_xfer(1);
    $display("test sync done");
    test_done();
  end
  initial begin
    #600000;
    num_errors++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
